/* File: logic/dtr_pkg.sv */
// Constants, types and state layout for the task-file reset/signature block.
// Assumes one 25 MHz clock shared with the link layer and the media engine.
package dtr_pkg;
  // ==========================================================================
  // Task-file register select codes
  localparam logic [2:0] SEL_ERROR      = 3'h0; // Read error_result, write features
  localparam logic [2:0] SEL_COUNT      = 3'h1;
  localparam logic [2:0] SEL_SECTOR     = 3'h2;
  localparam logic [2:0] SEL_CYL_LOW    = 3'h3;
  localparam logic [2:0] SEL_CYL_HIGH   = 3'h4;
  localparam logic [2:0] SEL_DRIVE_HEAD = 3'h5;
  localparam logic [2:0] SEL_STATUS     = 3'h6; // Read primary_status, write command
  localparam logic [2:0] SEL_SHADOW     = 3'h7; // Read shadow_status, write device control
  // ==========================================================================
  // Field positions
  localparam int unsigned DC_SOFT_RESET_BIT = 2;
  localparam int unsigned DH_LBA_BIT        = 6;
  localparam int unsigned ST_FAULT_BIT      = 5;
  localparam int unsigned ST_ERROR_BIT      = 0;
  // ==========================================================================
  // Reset values and signature
  localparam logic [7:0] RST_COUNT      = 8'h01;
  localparam logic [7:0] RST_SECTOR     = 8'h01;
  localparam logic [7:0] RST_CYL_LOW    = 8'h00;
  localparam logic [7:0] RST_CYL_HIGH   = 8'h00;
  localparam logic [7:0] RST_DRIVE_HEAD = 8'h00;
  localparam logic [7:0] RST_STATUS     = 8'h50;
  localparam logic [7:0] STATUS_BUSY    = 8'h80;
  localparam logic [7:0] SIG_COUNT      = 8'h01;
  localparam logic [7:0] SIG_LBA_LOW    = 8'h01;
  localparam logic [7:0] SIG_LBA_MID    = 8'h00;
  localparam logic [7:0] SIG_LBA_HIGH   = 8'h00;
  // ==========================================================================
  // Diagnostic codes
  localparam logic [7:0] DIAG_NO_ERROR   = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER  = 8'h02;
  localparam logic [7:0] DIAG_SECTOR_BUF = 8'h03;
  localparam logic [7:0] DIAG_ECC        = 8'h04;
  localparam logic [7:0] DIAG_CPU        = 8'h05;
  // ==========================================================================
  // Command and feature codes decoded locally
  localparam logic [7:0] CMD_READ_SECTORS = 8'h20;
  localparam logic [7:0] CMD_IDENTIFY     = 8'hEC;
  localparam logic [7:0] CMD_DIAGNOSTIC   = 8'h90;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] CMD_SLEEP        = 8'hE6;
  localparam logic [7:0] CMD_STANDBY_IMM  = 8'hE0;
  localparam logic [7:0] CMD_IDLE_IMM     = 8'hE1;
  localparam logic [7:0] FEAT_REVERT_ON   = 8'hCC;
  localparam logic [7:0] FEAT_REVERT_OFF  = 8'h66;
  // ==========================================================================
  // Types
  typedef enum logic [4:0] {
    RS_IDLE  = 5'h01,
    RS_START = 5'h02,
    RS_FLUSH = 5'h04,
    RS_DIAG  = 5'h08,
    RS_CMD   = 5'h10
  } dtr_seq_t;
  typedef enum logic [2:0] {
    PW_IDLE    = 3'h1,
    PW_STANDBY = 3'h2,
    PW_SLEEP   = 3'h4
  } dtr_pwr_t;
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [7:0]  error_code;
    logic        ncq_fail;
    logic [4:0]  ncq_tag;
    logic        unrec_valid;
    logic [27:0] unrec_lba;
  } dtr_done_t;
  typedef struct packed {
    logic        start;
    logic [7:0]  code;
    logic        lba_mode;
    logic [27:0] addr;
  } dtr_cmd_t;
  typedef struct packed {
    dtr_seq_t   seq;
    logic       por;
    logic [7:0] err, cnt, sec, cyl_lo, cyl_hi, dh, stat, feat, cmd;
    logic       soft_reset_request_bit_bit, revert_en, hold_standby;
    dtr_pwr_t   pwr;
    logic [7:0] rdata;
    dtr_cmd_t   cmd_out;
    logic       host_abort, dev_abort, diag_start, param_revert, spin_up, flush_req;
  } dtr_state_t;
endpackage : dtr_pkg

/* File: logic/dtr_taskfile.sv */
// Task-file register bank with reset response, diagnosis and signature output.
// Assumes link reset, host register accesses and media engine all run on clk_in.
// Assumes one media command at a time; completion fields are read only on valid.
// Pulses last one cycle; flush_req_out is a level held until the cache is clean.
// Operation
// - Failing queued command places its tag in the count field.
// - Load LBA fields with first unrecoverable error address when reported.
// - Error address is reported as given, no range check or data status.
// - Read, identify, diagnostic return signature in count and LBA, 27:24 reserved.
// - Error field carries diagnostic code in normal signature output; read and identify signatures leave it unchanged.
// - Signature status has bit 0 clear and bit 5 showing device fault.
// - Soft reset when control bit is set then cleared; interface resets.
// - Link or soft reset aborts host side now, device after cache flush.
// - Every reset and diagnostic command runs diagnosis, loads error code.
// - Power-on reverts parameters; other resets only when revert feature enabled.
// - Link or soft reset moves sleep to standby, keeps other modes.
// - After power-on enter idle, or standby when hold feature enabled.
// - Power-on spins spindle unless hold enabled; other resets never spin.
// - Resets load count, sector 01h, cylinders, head 00h, status 50h.
// - Diagnostic codes 01h to 05h as listed.
// - Drive/head select bit 6 chooses LBA per command.
// - LBA built from drive/head, cylinder high, cylinder low, sector number.
`timescale 1ns/100ps
module dtr_taskfile (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              link_reset_in,
  input  wire logic              tf_write_in,
  input  wire logic              tf_read_in,
  input  wire logic [2:0]        tf_select_in,
  input  wire logic [7:0]        tf_wdata_in,
  output logic      [7:0]        tf_rdata_out,
  input  wire logic              hold_standby_in,
  input  wire logic              dev_fault_in,
  input  wire logic              cache_clean_in,
  input  wire logic              diag_done_in,
  input  wire logic [7:0]        diag_code_in,
  input  wire dtr_pkg::dtr_done_t cmd_done_in,
  output dtr_pkg::dtr_cmd_t      cmd_out,
  output logic [2:0]             power_mode_out,
  output logic                   host_abort_out,
  output logic                   dev_abort_out,
  output logic                   diag_start_out,
  output logic                   param_revert_out,
  output logic                   spin_up_out,
  output logic                   flush_req_out
);
  import dtr_pkg::*;

  // ==========================================================================
  // State and decode
  dtr_state_t st;
  dtr_state_t next_st;
  logic       soft_reset_request_bit_fall;
  logic       cmd_wr;
  logic [7:0] fault_mask;

  // ==========================================================================
  // Decode
  always_comb begin
    // Fault bit is merged in each time ready status 50h is loaded; busy status carries no fault bit
    fault_mask = 8'h00;
    fault_mask[ST_FAULT_BIT] = dev_fault_in;
    // Soft reset fires when a set control bit is written back to zero
    soft_reset_request_bit_fall = tf_write_in && (tf_select_in == SEL_SHADOW) && st.soft_reset_request_bit_bit &&
                !tf_wdata_in[DC_SOFT_RESET_BIT];
    // Commands are refused while a reset runs or the drive sleeps
    cmd_wr = tf_write_in && (tf_select_in == SEL_STATUS) && (st.seq == RS_IDLE) &&
             (st.pwr != PW_SLEEP);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.host_abort   = 1'b0;
    next_st.dev_abort    = 1'b0;
    next_st.diag_start   = 1'b0;
    next_st.param_revert = 1'b0;
    next_st.spin_up      = 1'b0;
    next_st.cmd_out.start = 1'b0;

    // ========================================================================
    // Register reads; both status copies return the same byte
    if (tf_read_in) begin
      unique case (tf_select_in)
        SEL_ERROR:      next_st.rdata = st.err;
        SEL_COUNT:      next_st.rdata = st.cnt;
        SEL_SECTOR:     next_st.rdata = st.sec;
        SEL_CYL_LOW:    next_st.rdata = st.cyl_lo;
        SEL_CYL_HIGH:   next_st.rdata = st.cyl_hi;
        SEL_DRIVE_HEAD: next_st.rdata = st.dh;
        SEL_STATUS:     next_st.rdata = st.stat;
        SEL_SHADOW:     next_st.rdata = st.stat;
      endcase
    end

    // ========================================================================
    // Host writes other than the device control bit only land while idle, so reset values are not disturbed mid-sequence
    if (tf_write_in && (st.seq == RS_IDLE)) begin
      unique case (tf_select_in)
        SEL_ERROR:      next_st.feat   = tf_wdata_in;
        SEL_COUNT:      next_st.cnt    = tf_wdata_in;
        SEL_SECTOR:     next_st.sec    = tf_wdata_in;
        SEL_CYL_LOW:    next_st.cyl_lo = tf_wdata_in;
        SEL_CYL_HIGH:   next_st.cyl_hi = tf_wdata_in;
        SEL_DRIVE_HEAD: next_st.dh     = tf_wdata_in;
        SEL_STATUS:     next_st.cmd    = tf_wdata_in;
        SEL_SHADOW:     next_st.cmd    = st.cmd;
      endcase
    end
    if (tf_write_in && (tf_select_in == SEL_SHADOW)) begin
      next_st.soft_reset_request_bit_bit = tf_wdata_in[DC_SOFT_RESET_BIT];
    end

    // ========================================================================
    // New command
    if (cmd_wr) begin
      next_st.stat = STATUS_BUSY;
      unique case (tf_wdata_in)
        // Local commands never reach the media engine; all but the diagnostic command finish here
        CMD_DIAGNOSTIC: begin
          next_st.diag_start = 1'b1;
          next_st.seq = RS_DIAG;
        end
        CMD_SET_FEATURES: begin
          if (st.feat == FEAT_REVERT_ON) begin
            next_st.revert_en = 1'b1;
          end else if (st.feat == FEAT_REVERT_OFF) begin
            next_st.revert_en = 1'b0;
          end
          next_st.stat = RST_STATUS | fault_mask;
        end
        CMD_SLEEP: begin
          next_st.pwr  = PW_SLEEP;
          next_st.stat = RST_STATUS | fault_mask;
        end
        CMD_STANDBY_IMM: begin
          next_st.pwr  = PW_STANDBY;
          next_st.stat = RST_STATUS | fault_mask;
        end
        CMD_IDLE_IMM: begin
          next_st.pwr  = PW_IDLE;
          next_st.stat = RST_STATUS | fault_mask;
        end
        // Anything else goes out with the address exactly as written
        default: begin
          next_st.cmd_out.start    = 1'b1;
          next_st.cmd_out.code     = tf_wdata_in;
          next_st.cmd_out.lba_mode = st.dh[DH_LBA_BIT];
          next_st.cmd_out.addr     = {st.dh[3:0], st.cyl_hi, st.cyl_lo, st.sec};
          next_st.seq = RS_CMD;
        end
      endcase
    end

    // ========================================================================
    // Sequencer
    unique case (st.seq)
      RS_IDLE: begin
        // Registers hold until the host writes or a new command ends
      end
      RS_CMD: begin
        // Completion fields are only trusted on the valid pulse
        if (cmd_done_in.valid) begin
          next_st.seq = RS_IDLE;
          if (cmd_done_in.error) begin
            next_st.err  = cmd_done_in.error_code;
            next_st.stat = RST_STATUS | fault_mask;
            next_st.stat[ST_ERROR_BIT] = 1'b1;
            if (cmd_done_in.ncq_fail) begin
              next_st.cnt = {3'h0, cmd_done_in.ncq_tag};
            end
            if (cmd_done_in.unrec_valid) begin
              // Address taken verbatim, it may lie outside the command range
              next_st.sec    = cmd_done_in.unrec_lba[7:0];
              next_st.cyl_lo = cmd_done_in.unrec_lba[15:8];
              next_st.cyl_hi = cmd_done_in.unrec_lba[23:16];
              next_st.dh     = {st.dh[7:4], cmd_done_in.unrec_lba[27:24]};
            end
          end else begin
            next_st.stat = RST_STATUS | fault_mask;
            if ((st.cmd == CMD_READ_SECTORS) || (st.cmd == CMD_IDENTIFY)) begin
              next_st.cnt    = SIG_COUNT;
              next_st.sec    = SIG_LBA_LOW;
              next_st.cyl_lo = SIG_LBA_MID;
              next_st.cyl_hi = SIG_LBA_HIGH;
              next_st.dh     = {st.dh[7:4], 4'h0};
            end
          end
        end
      end
      RS_FLUSH: begin
        // Device operation is held until the write cache reaches the media
        if (cache_clean_in) begin
          next_st.flush_req    = 1'b0;
          next_st.dev_abort    = 1'b1;
          next_st.param_revert = st.revert_en;
          if (st.pwr == PW_SLEEP) begin
            next_st.pwr = PW_STANDBY;
          end
          next_st.seq = RS_START;
        end
      end
      RS_START: begin
        // Registers take their defaults as diagnosis is started
        next_st.cnt    = RST_COUNT;
        next_st.sec    = RST_SECTOR;
        next_st.cyl_lo = RST_CYL_LOW;
        next_st.cyl_hi = RST_CYL_HIGH;
        next_st.dh     = RST_DRIVE_HEAD;
        next_st.stat   = STATUS_BUSY;
        next_st.diag_start = 1'b1;
        if (st.por) begin
          // Strap is caught here, one edge after release, never under reset
          next_st.hold_standby = hold_standby_in;
          next_st.param_revert = 1'b1;
          next_st.spin_up      = !hold_standby_in;
          next_st.pwr          = hold_standby_in ? PW_STANDBY : PW_IDLE;
          next_st.por          = 1'b0;
        end
        next_st.seq = RS_DIAG;
      end
      RS_DIAG: begin
        // Busy status stays until the diagnosis unit answers
        if (diag_done_in) begin
          next_st.err  = diag_code_in;
          next_st.stat = RST_STATUS | fault_mask;
          next_st.seq  = RS_IDLE;
          if (st.cmd == CMD_DIAGNOSTIC) begin
            next_st.cnt    = SIG_COUNT;
            next_st.sec    = SIG_LBA_LOW;
            next_st.cyl_lo = SIG_LBA_MID;
            next_st.cyl_hi = SIG_LBA_HIGH;
            next_st.dh     = {st.dh[7:4], 4'h0};
          end
        end
      end
    endcase

    // ========================================================================
    // Link or soft reset overrides anything in flight
    // A reset during a flush restarts it; the cache must still drain first
    if (link_reset_in || soft_reset_request_bit_fall) begin
      next_st.host_abort = 1'b1;
      next_st.flush_req  = 1'b1;
      next_st.cmd        = 8'h00;
      next_st.stat       = STATUS_BUSY;
      next_st.seq        = RS_FLUSH;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '{
        // Reset sequence starts on the first edge after release
        seq:          RS_START,
        por:          1'b1,
        err:          8'h00,
        // Task-file registers at their defaults
        cnt:          RST_COUNT,
        sec:          RST_SECTOR,
        cyl_lo:       RST_CYL_LOW,
        cyl_hi:       RST_CYL_HIGH,
        dh:           RST_DRIVE_HEAD,
        // Busy until the first diagnosis has answered
        stat:         STATUS_BUSY,
        feat:         8'h00,
        cmd:          8'h00,
        soft_reset_request_bit_bit:     1'b0,
        revert_en:    1'b0,
        // Standby until the hold strap is read on the first edge
        hold_standby: 1'b0,
        pwr:          PW_STANDBY,
        rdata:        8'h00,
        cmd_out:      '0,
        // All pulses low
        host_abort:   1'b0,
        dev_abort:    1'b0,
        diag_start:   1'b0,
        param_revert: 1'b0,
        spin_up:      1'b0,
        flush_req:    1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  // Every output is a state field, so none has logic after its flop
  assign tf_rdata_out     = st.rdata;
  assign cmd_out          = st.cmd_out;
  assign power_mode_out   = st.pwr;
  assign host_abort_out   = st.host_abort;
  assign dev_abort_out    = st.dev_abort;
  assign diag_start_out   = st.diag_start;
  assign param_revert_out = st.param_revert;
  assign spin_up_out      = st.spin_up;
  assign flush_req_out    = st.flush_req;
endmodule // dtr_taskfile

/* File: tb/dtr_media_model.sv */
// Behavioural media engine, diagnosis unit and write cache.
// Assumes the block's clock; answers after short fixed delays.
`timescale 1ns/100ps
module dtr_media_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire dtr_pkg::dtr_cmd_t cmd_in,
  input  wire logic       diag_start_in,
  input  wire logic       flush_req_in,
  input  wire logic [7:0] code_in,
  input  wire logic       fail_in,
  output logic            diag_done_out,
  output logic [7:0]      diag_code_out,
  output dtr_pkg::dtr_done_t done_out,
  output logic            cache_clean_out
);
  import dtr_pkg::*;
  logic [3:0]  dly, cdly, fl;
  logic [43:0] pay;
  // ==========================================================================
  // Delays; cache drains a few cycles after a flush request
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dly <= 4'h0;
      cdly <= 4'h0;
      fl <= 4'h0;
    end else begin
      dly <= diag_start_in ? 4'h3 : dly - {3'h0, dly != 4'h0};
      cdly <= cmd_in.start ? 4'h4 : cdly - {3'h0, cdly != 4'h0};
      fl <= flush_req_in ? fl + {3'h0, fl != 4'hF} : 4'h0;
    end
  end
  // Fields outside their valid cycle show inverted junk, not the last value
  assign pay = {fail_in, 8'h04, fail_in, 5'h0B, fail_in, 28'h0ABCDEF};
  assign diag_done_out = (dly == 4'h1);
  assign diag_code_out = diag_done_out ? code_in : ~code_in;
  assign done_out = {cdly == 4'h1, (cdly == 4'h1) ? pay : ~pay};
  assign cache_clean_out = (fl >= 4'h3);
endmodule // dtr_media_model

/* File: tb/dtr_props.sv */
// Checker for the task-file reset and signature block.
// Assumes it is bound to every dtr_taskfile instance; one clock domain.
`timescale 1ns/100ps
module dtr_props (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       link_reset_in,
  input wire logic       tf_read_in,
  input wire logic [7:0] tf_rdata_out,
  input wire logic       cache_clean_in,
  input wire dtr_pkg::dtr_cmd_t cmd_out,
  input wire logic [2:0] power_mode_out,
  input wire logic       host_abort_out,
  input wire logic       dev_abort_out,
  input wire logic       diag_start_out,
  input wire logic       param_revert_out,
  input wire logic       spin_up_out,
  input wire logic       flush_req_out
);
  import dtr_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================================================
  // Properties
  property p_por_diag;
    $fell(reset_in) |-> ##[0:1] diag_start_out;
  endproperty
  a_por_diag: assert property (p_por_diag) else $error("no diagnosis after power-on");
  property p_host_abort;
    link_reset_in |=> host_abort_out && flush_req_out;
  endproperty
  a_host_abort: assert property (p_host_abort) else $error("no host abort");
  property p_dev_abort;
    dev_abort_out |-> $past(cache_clean_in) && $past(flush_req_out);
  endproperty
  a_dev_abort: assert property (p_dev_abort) else $error("abort before flush");
  property p_flush_hold;
    flush_req_out && !cache_clean_in |=> flush_req_out;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush dropped early");
  property p_diag_after;
    dev_abort_out |=> diag_start_out;
  endproperty
  a_diag_after: assert property (p_diag_after) else $error("no diagnosis after reset");
  property p_revert;
    param_revert_out |-> dev_abort_out || diag_start_out;
  endproperty
  a_revert: assert property (p_revert) else $error("stray revert");
  property p_sleep_wake;
    power_mode_out == PW_SLEEP && link_reset_in |-> ##[1:20] power_mode_out == PW_STANDBY;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left");
  property p_mode_keep;
    flush_req_out && power_mode_out != PW_SLEEP |=> $stable(power_mode_out);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode changed on reset");
  property p_no_spin;
    host_abort_out |=> !spin_up_out [*4];
  endproperty
  a_no_spin: assert property (p_no_spin) else $error("spin on link reset");
  property p_rdata_hold;
    !tf_read_in |=> $stable(tf_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  c_link: cover property (link_reset_in ##1 host_abort_out);
  c_sleep: cover property (power_mode_out == PW_SLEEP ##1 flush_req_out);
  c_cmd: cover property (cmd_out.start && cmd_out.lba_mode);
endmodule // dtr_props

bind dtr_taskfile dtr_props u_props (
  .clk_in(clk_in), .reset_in(reset_in), .link_reset_in(link_reset_in),
  .tf_read_in(tf_read_in), .tf_rdata_out(tf_rdata_out), .cache_clean_in(cache_clean_in),
  .cmd_out(cmd_out), .power_mode_out(power_mode_out), .host_abort_out(host_abort_out),
  .dev_abort_out(dev_abort_out), .diag_start_out(diag_start_out),
  .param_revert_out(param_revert_out), .spin_up_out(spin_up_out),
  .flush_req_out(flush_req_out));

/* File: tb/tb_top.sv */
// Self-checking bench: host register accesses against the task-file block.
// Assumes the media model answers commands and diagnosis within a few cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import dtr_pkg::*;
  logic clk_in, reset_in, link_reset_in, tf_write_in, tf_read_in, hold_standby_in;
  logic dev_fault_in, cache_clean_in, diag_done_in, fail, diag_done_seen;
  logic [2:0]  tf_select_in, power_mode_out;
  logic [7:0]  tf_wdata_in, tf_rdata_out, diag_code_in, code;
  logic        host_abort_out, dev_abort_out, diag_start_out, param_revert_out;
  logic        spin_up_out, flush_req_out, seen_lba;
  logic [27:0] seen_addr;
  dtr_done_t   cmd_done_in;
  dtr_cmd_t    cmd_out;
  int          bad_count, n_checks, n_rev, n_spin, rev0, c;
  dtr_taskfile dut (.clk_in(clk_in), .reset_in(reset_in), .link_reset_in(link_reset_in),
    .tf_write_in(tf_write_in), .tf_read_in(tf_read_in), .tf_select_in(tf_select_in),
    .tf_wdata_in(tf_wdata_in), .tf_rdata_out(tf_rdata_out), .hold_standby_in(hold_standby_in),
    .dev_fault_in(dev_fault_in), .cache_clean_in(cache_clean_in), .diag_done_in(diag_done_in),
    .diag_code_in(diag_code_in), .cmd_done_in(cmd_done_in), .cmd_out(cmd_out),
    .power_mode_out(power_mode_out), .host_abort_out(host_abort_out),
    .dev_abort_out(dev_abort_out), .diag_start_out(diag_start_out),
    .param_revert_out(param_revert_out), .spin_up_out(spin_up_out),
    .flush_req_out(flush_req_out));
  dtr_media_model u_media (.clk_in(clk_in), .reset_in(reset_in), .cmd_in(cmd_out),
    .diag_start_in(diag_start_out), .flush_req_in(flush_req_out), .code_in(code),
    .fail_in(fail), .diag_done_out(diag_done_in), .diag_code_out(diag_code_in),
    .done_out(cmd_done_in), .cache_clean_out(cache_clean_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (cmd_out.start === 1'b1) begin
      seen_addr <= cmd_out.addr;
      seen_lba <= cmd_out.lba_mode;
    end
    if (param_revert_out === 1'b1) n_rev <= n_rev + 1;
    if (spin_up_out === 1'b1) n_spin <= n_spin + 1;
  end
  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_in);
    tf_write_in <= 1'b1;
    tf_select_in <= s;
    tf_wdata_in <= d;
    @(posedge clk_in);
    tf_write_in <= 1'b0;
  endtask
  task automatic get(input logic [2:0] s);
    @(posedge clk_in);
    tf_read_in <= 1'b1;
    tf_select_in <= s;
    @(posedge clk_in);
    tf_read_in <= 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    get(s);
    `CHK(tf_rdata_out, e)
  endtask
  task automatic ready();
    int k;
    for (k = 0; k < 40; k++) begin
      get(SEL_STATUS);
      if (tf_rdata_out[7] === 1'b0) break;
    end
    if (k == 40) begin
      bad_count++;
      conclude();
    end
  endtask
  // Bank read twice from register lo upward; results must not drift between reads
  task automatic chk_regs(input int lo, input logic [7:0] e0, dh, st);
    for (int r = 0; r < 2; r++)
      for (int i = lo; i < 8; i++)
        rd(3'(i), i == 0 ? e0 : i >= 6 ? st : i == 5 ? dh : i < 3 ? 8'h01 : 8'h00);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    {reset_in, link_reset_in, tf_write_in, tf_read_in, hold_standby_in} = 5'h10;
    {dev_fault_in, fail, tf_select_in, tf_wdata_in} = '0;
    {bad_count, n_checks, n_rev, n_spin} = '0;
    code = DIAG_NO_ERROR;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    ready();
    `CHK(power_mode_out, 3'h1)
    `CHK(n_spin, 1)
    chk_regs(0, DIAG_NO_ERROR, 8'h00, 8'h50);
    $display("power-on defaults done");
    for (c = 1; c <= 5; c++) begin
      code <= 8'(c);
      dev_fault_in <= (c == 5);
      wr(SEL_STATUS, CMD_DIAGNOSTIC);
      ready();
      chk_regs(0, 8'(c), 8'h00, c == 5 ? 8'h70 : 8'h50);
    end
    {code, dev_fault_in} <= {DIAG_NO_ERROR, 1'b0};
    $display("diagnostic codes done");
    wr(SEL_DRIVE_HEAD, 8'hE5);
    wr(SEL_CYL_HIGH, 8'h34);
    wr(SEL_CYL_LOW, 8'h12);
    wr(SEL_SECTOR, 8'h78);
    wr(SEL_STATUS, CMD_READ_SECTORS);
    ready();
    `CHK(seen_addr, 28'h5341278)
    `CHK(seen_lba, 1'b1)
    chk_regs(1, 8'h00, 8'hE0, 8'h50);
    wr(SEL_DRIVE_HEAD, 8'hA3);
    fail <= 1'b1;
    wr(SEL_STATUS, CMD_READ_SECTORS);
    ready();
    fail <= 1'b0;
    `CHK(seen_lba, 1'b0)
    rd(SEL_COUNT, 8'h0B);
    rd(SEL_SECTOR, 8'hEF);
    rd(SEL_CYL_LOW, 8'hCD);
    rd(SEL_CYL_HIGH, 8'hAB);
    rd(SEL_STATUS, 8'h51);
    rd(SEL_DRIVE_HEAD, 8'hA0);
    $display("media commands done");
    rev0 = n_rev;
    wr(SEL_STATUS, CMD_SLEEP);
    link_reset_in <= 1'b1;
    @(negedge clk_in);
    `CHK(power_mode_out, 3'h4)
    @(posedge clk_in);
    link_reset_in <= 1'b0;
    ready();
    `CHK(power_mode_out, 3'h2)
    `CHK(n_rev - rev0, 0)
    chk_regs(0, DIAG_NO_ERROR, 8'h00, 8'h50);
    $display("link reset done");
    wr(SEL_ERROR, FEAT_REVERT_ON);
    wr(SEL_STATUS, CMD_SET_FEATURES);
    wr(SEL_SHADOW, 8'h04);
    wr(SEL_SHADOW, 8'h00);
    ready();
    `CHK(n_rev - rev0, 1)
    `CHK(power_mode_out, 3'h2)
    chk_regs(0, DIAG_NO_ERROR, 8'h00, 8'h50);
    $display("soft reset done");
    wr(SEL_STATUS, CMD_IDLE_IMM);
    wr(SEL_CYL_LOW, 8'h5A);
    wr(SEL_STATUS, CMD_IDENTIFY);
    ready();
    chk_regs(1, 8'h00, 8'h00, 8'h50);
    wr(SEL_ERROR, FEAT_REVERT_OFF);
    wr(SEL_STATUS, CMD_SET_FEATURES);
    wr(SEL_SHADOW, 8'h04);
    wr(SEL_SHADOW, 8'h00);
    ready();
    `CHK(n_rev - rev0, 1)
    `CHK(power_mode_out, 3'h1)
    $display("identify and idle soft reset done");
    wr(SEL_CYL_HIGH, 8'h77);
    @(posedge clk_in);
    {reset_in, hold_standby_in} <= 2'h3;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    ready();
    `CHK(power_mode_out, 3'h2)
    `CHK(n_spin, 1)
    `CHK(n_rev - rev0, 2)
    chk_regs(0, DIAG_NO_ERROR, 8'h00, 8'h50);
    $display("second power-on done");
    conclude();
  end
endmodule // tb_top
